// ===== rtl/acd_defines.vh
`ifndef ACD_DEFINES_VH
`define ACD_DEFINES_VH
// Channel counts and data widths.
`define ACD_NUM_ADC 8
`define ACD_NUM_DAC 2
`define ACD_DATA_W 12
`define ACD_CH_W 3
// Code limits of the 12-bit converters.
`define ACD_CODE_MAX 12'hFFF
`define ACD_CODE_MID 12'h800
// Gain trim denominator and fixed-point reciprocal (2^32 / 10000, rounded).
`define ACD_GAIN_DEN 16'h2710
`define ACD_GAIN_RECIP 20'h68DB9
`define ACD_GAIN_FRAC 32
// Allowed zero-offset range.
`define ACD_OFS_MIN (-16'sd100)
`define ACD_OFS_MAX 16'sd100
// Moving average depth limits (window holds up to 16 samples).
`define ACD_AVG_MAX 5'h10
`define ACD_AVG_DEPTH 16
`define ACD_AVG_IDX_W 4
// Reset values of loaded constants.
`define ACD_GAIN_RST 16'h0000
`define ACD_OFS_RST 8'h00
`define ACD_AVG_RST 5'h01
`endif

// ===== rtl/acd_sample_mem.v
`timescale 1ns/100ps
// Sample history for all input channels; read data is registered.
module acd_sample_mem
(
  input wire clock_i, // system clock
  input wire we_i, // write strobe
  input wire [6:0] waddr_i, // write address {channel, slot}
  input wire [11:0] wdata_i, // write data
  input wire [6:0] raddr_i, // read address {channel, slot}
  output reg [11:0] rdata_o // registered read data
);
  reg [11:0] mem_q [0:127];

  always @(posedge clock_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule // acd_sample_mem

// ===== rtl/acd_calib_datapath.v
`timescale 1ns/100ps
`include "acd_defines.vh"
module acd_calib_datapath
(
  input wire clock_i, // 100 MHz system clock
  input wire rst_i, // asynchronous power-on reset, active high
  input wire cold_boot_i, // pulse: cold boot loads staged constants
  input wire cfg_we_i, // pulse: write a staged constant
  input wire [1:0] cfg_sel_i, // 0 adc gain, 1 adc offset, 2 dac gain, 3 dac offset
  input wire [2:0] cfg_ch_i, // channel of the staged constant
  input wire [15:0] cfg_data_i, // signed constant value
  input wire [4:0] cfg_avg_i, // staged averaging depth 1..16
  input wire cfg_done_i, // pulse: parameter transfer complete
  input wire reboot_after_save_i, // level: restart once parameters arrive
  output reg reboot_req_o, // pulse: internal restart requested
  input wire adc_valid_i, // pulse: raw sample present
  input wire [2:0] adc_ch_i, // channel of raw sample
  input wire [11:0] adc_data_i, // raw converter sample
  output reg adc_valid_o, // pulse: corrected reading updated
  output reg [2:0] adc_ch_o, // channel of corrected reading
  output reg [11:0] adc_data_o, // corrected reading
  input wire output_set_command_i, // pulse: new output set value
  input wire output_set_ch_i, // output channel
  input wire [11:0] output_set_value_i, // requested set value
  output reg dac_we_o, // pulse: write to output converter
  output reg dac_ch_o, // converter channel
  output reg [11:0] dac_data_o // corrected converter code
);
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_ACC = 2'h2;
  localparam ST_OUT = 2'h3;
  // Offset clamp limits; the low byte is the staged 8-bit form.
  localparam [15:0] OFS_HI = `ACD_OFS_MAX;
  localparam [15:0] OFS_LO = `ACD_OFS_MIN;

  // Staged constants (written by configuration) and active constants.
  reg signed [15:0] stg_adc_gain_q [0:7];
  reg signed [7:0] stg_adc_ofs_q [0:7];
  reg signed [15:0] stg_dac_gain_q [0:1];
  reg signed [7:0] stg_dac_ofs_q [0:1];
  reg signed [15:0] act_adc_gain_q [0:7];
  reg signed [7:0] act_adc_ofs_q [0:7];
  reg signed [15:0] act_dac_gain_q [0:1];
  reg signed [7:0] act_dac_ofs_q [0:1];
  reg [4:0] stg_avg_q;
  reg [4:0] act_avg_q;
  reg load_q;
  wire load_now;
  wire [7:0] cfg_ofs_clamped;

  // Offsets beyond the allowed range are clamped at staging time.
  assign cfg_ofs_clamped = ($signed(cfg_data_i) > `ACD_OFS_MAX) ? OFS_HI[7:0] :
    ($signed(cfg_data_i) < `ACD_OFS_MIN) ? OFS_LO[7:0] : cfg_data_i[7:0];
  // A staged write in the same cycle as a load misses that load.
  assign load_now = cold_boot_i | load_q;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_adc
      always @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          stg_adc_gain_q[gi] <= `ACD_GAIN_RST;
          stg_adc_ofs_q[gi] <= `ACD_OFS_RST;
          act_adc_gain_q[gi] <= `ACD_GAIN_RST;
          act_adc_ofs_q[gi] <= `ACD_OFS_RST;
        end
        else
        begin
          if (cfg_we_i && cfg_ch_i == gi && cfg_sel_i == 2'h0)
            stg_adc_gain_q[gi] <= cfg_data_i;
          if (cfg_we_i && cfg_ch_i == gi && cfg_sel_i == 2'h1)
            stg_adc_ofs_q[gi] <= cfg_ofs_clamped;
          if (load_now)
          begin
            act_adc_gain_q[gi] <= stg_adc_gain_q[gi];
            act_adc_ofs_q[gi] <= stg_adc_ofs_q[gi];
          end
        end
      end
    end
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_dac
      always @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          stg_dac_gain_q[gi] <= `ACD_GAIN_RST;
          stg_dac_ofs_q[gi] <= `ACD_OFS_RST;
          act_dac_gain_q[gi] <= `ACD_GAIN_RST;
          act_dac_ofs_q[gi] <= `ACD_OFS_RST;
        end
        else
        begin
          if (cfg_we_i && cfg_ch_i == gi && cfg_sel_i == 2'h2)
            stg_dac_gain_q[gi] <= cfg_data_i;
          if (cfg_we_i && cfg_ch_i == gi && cfg_sel_i == 2'h3)
            stg_dac_ofs_q[gi] <= cfg_ofs_clamped;
          if (load_now)
          begin
            act_dac_gain_q[gi] <= stg_dac_gain_q[gi];
            act_dac_ofs_q[gi] <= stg_dac_ofs_q[gi];
          end
        end
      end
    end
  endgenerate

  // Restart sequence: request a reboot and load in the same cycle.
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stg_avg_q <= `ACD_AVG_RST;
      act_avg_q <= `ACD_AVG_RST;
      load_q <= 1'b0;
      reboot_req_o <= 1'b0;
    end
    else
    begin
      if (cfg_we_i)
        stg_avg_q <= (cfg_avg_i == 5'h00) ? `ACD_AVG_RST :
          (cfg_avg_i > `ACD_AVG_MAX) ? `ACD_AVG_MAX : cfg_avg_i;
      reboot_req_o <= cfg_done_i & reboot_after_save_i;
      load_q <= cfg_done_i & reboot_after_save_i;
      if (load_now)
        act_avg_q <= stg_avg_q;
    end
  end

  // Gain + offset correction, shared by both paths. The reciprocal of
  // 10000 is held with 32 fractional bits so that trim error stays far
  // below one code even at the largest trim; a shorter reciprocal drifts
  // past one code once the trim grows into the thousands.
  function [11:0] correct;
    input [11:0] value;
    input signed [15:0] trim;
    input signed [7:0] ofs;
    reg signed [63:0] prod;
    reg signed [63:0] scaled;
    reg signed [63:0] sum;
    begin
      prod = $signed({52'h0, value}) * trim * $signed({44'h0, `ACD_GAIN_RECIP});
      // Round to nearest before dropping the fraction.
      scaled = $signed({52'h0, value}) +
        ((prod + 64'sh80000000) >>> `ACD_GAIN_FRAC);
      sum = scaled + ofs;
      if (sum < 0)
        correct = 12'h000;
      else if (sum > $signed({52'h0, `ACD_CODE_MAX}))
        correct = `ACD_CODE_MAX;
      else
        correct = sum[11:0];
    end
  endfunction

  // Output path: one-cycle registered correction. With zero trims the
  // code passes unchanged, so 2048 stays midscale.
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dac_we_o <= 1'b0;
      dac_ch_o <= 1'b0;
      dac_data_o <= 12'h000;
    end
    else
    begin
      dac_we_o <= output_set_command_i;
      if (output_set_command_i)
      begin
        dac_ch_o <= output_set_ch_i;
        dac_data_o <= correct(output_set_value_i, act_dac_gain_q[output_set_ch_i],
          act_dac_ofs_q[output_set_ch_i]);
      end
    end
  end

  // Input path: each sample is stored in a per-channel ring, then the
  // last N entries are summed one per cycle. Samples arriving while a
  // sum is in progress are dropped; converters sample far slower.
  reg [1:0] st_q;
  reg [2:0] ch_q;
  reg [3:0] wr_ptr_q [0:7];
  reg [3:0] rd_idx_q;
  reg [4:0] cnt_q;
  reg [4:0] depth_q;
  reg [15:0] acc_q;
  reg [4:0] fill_q [0:7];
  reg [11:0] newest_q;
  wire mem_we;
  wire [11:0] mem_rdata;
  wire [15:0] avg_val;
  wire [4:0] eff_depth;
  integer k;

  assign mem_we = (st_q == ST_IDLE) && adc_valid_i;

  // Until a channel holds N samples only the ones it has are averaged;
  // after power-on the unwritten slots of its ring hold nothing useful.
  assign eff_depth = (fill_q[adc_ch_i] < act_avg_q) ?
    (fill_q[adc_ch_i] + 5'h01) : act_avg_q;

  acd_sample_mem u_mem
  (
    .clock_i(clock_i),
    .we_i(mem_we),
    .waddr_i({adc_ch_i, wr_ptr_q[adc_ch_i]}),
    .wdata_i(adc_data_i),
    .raddr_i({ch_q, rd_idx_q}),
    .rdata_o(mem_rdata)
  );

  // Divide by depth; depth 1 bypasses averaging entirely.
  assign avg_val = (depth_q == 5'h01) ? {4'h0, newest_q} : (acc_q / {11'h0, depth_q});

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= ST_IDLE;
      ch_q <= 3'h0;
      rd_idx_q <= 4'h0;
      cnt_q <= 5'h00;
      depth_q <= `ACD_AVG_RST;
      acc_q <= 16'h0000;
      newest_q <= 12'h000;
      adc_valid_o <= 1'b0;
      adc_ch_o <= 3'h0;
      adc_data_o <= 12'h000;
      for (k = 0; k < 8; k = k + 1)
      begin
        wr_ptr_q[k] <= 4'h0;
        fill_q[k] <= 5'h00;
      end
    end
    else
    begin
      adc_valid_o <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (adc_valid_i)
          begin
            ch_q <= adc_ch_i;
            newest_q <= adc_data_i;
            depth_q <= eff_depth;
            rd_idx_q <= wr_ptr_q[adc_ch_i];
            wr_ptr_q[adc_ch_i] <= wr_ptr_q[adc_ch_i] + 4'h1;
            cnt_q <= eff_depth;
            acc_q <= 16'h0000;
            // The count stops at the ring size, so it never wraps back to zero.
            if (fill_q[adc_ch_i] != `ACD_AVG_MAX)
              fill_q[adc_ch_i] <= fill_q[adc_ch_i] + 5'h01;
            st_q <= (eff_depth == 5'h01) ? ST_OUT : ST_READ;
          end
        end
        ST_READ:
        begin
          // Write landed on the edge into this state; first read issued now.
          rd_idx_q <= rd_idx_q - 4'h1;
          cnt_q <= cnt_q - 5'h01;
          st_q <= ST_ACC;
        end
        ST_ACC:
        begin
          acc_q <= acc_q + {4'h0, mem_rdata};
          if (cnt_q == 5'h00)
            st_q <= ST_OUT;
          else
          begin
            rd_idx_q <= rd_idx_q - 4'h1;
            cnt_q <= cnt_q - 5'h01;
          end
        end
        ST_OUT:
        begin
          adc_valid_o <= 1'b1;
          adc_ch_o <= ch_q;
          adc_data_o <= correct(avg_val[11:0], act_adc_gain_q[ch_q],
            act_adc_ofs_q[ch_q]);
          st_q <= ST_IDLE;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // acd_calib_datapath

// ===== verif/acd_calib_datapath_assertions.sv
`timescale 1ns/100ps
module acd_calib_datapath_assertions
(
  input wire clock_i, // clock
  input wire rst_i, // reset
  input wire cfg_done_i, // transfer done
  input wire reboot_after_save_i, // restart select
  input wire reboot_req_o, // restart pulse
  input wire adc_valid_i, // raw sample
  input wire adc_valid_o, // reading strobe
  input wire output_set_command_i, // set command
  input wire output_set_ch_i, // set channel
  input wire dac_we_o, // converter strobe
  input wire dac_ch_o, // converter channel
  input wire [11:0] dac_data_o // converter code
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  reg [4:0] gap_q;
  // Saturates so that a long idle spell cannot wrap into the answer window.
  always @(posedge clock_i or posedge rst_i)
    if (rst_i)
      gap_q <= 5'h1F;
    else if (adc_valid_i)
      gap_q <= 5'h00;
    else if (gap_q != 5'h1F)
      gap_q <= gap_q + 5'h01;
  AST_DAC_LAT: assert property (output_set_command_i |=> dac_we_o &&
    dac_ch_o == $past(output_set_ch_i)) else $error("converter write missing");
  AST_DAC_QUIET: assert property (!output_set_command_i |=> !dac_we_o)
    else $error("converter write without command");
  AST_DAC_HOLD: assert property (!output_set_command_i |=> $stable(dac_data_o))
    else $error("converter code moved");
  AST_REBOOT: assert property (cfg_done_i && reboot_after_save_i |=> reboot_req_o)
    else $error("restart missing");
  AST_NO_REBOOT: assert property (!(cfg_done_i && reboot_after_save_i) |=> !reboot_req_o)
    else $error("restart without request");
  AST_ADC_PULSE: assert property (adc_valid_o |=> !adc_valid_o)
    else $error("reading strobe too long");
  AST_ADC_LAT: assert property (adc_valid_o |-> gap_q >= 5'h01 && gap_q <= 5'h13)
    else $error("reading out of window");
  AST_ADC_ANSWER: assert property (adc_valid_i && gap_q >= 5'h14 |-> ##[2:20] adc_valid_o)
    else $error("reading never came");
  cover property (reboot_req_o);
  cover property (dac_we_o ##1 dac_we_o);
  cover property (adc_valid_o);
endmodule // acd_calib_datapath_assertions
bind acd_calib_datapath acd_calib_datapath_assertions acd_calib_datapath_assertions_i (
  .clock_i(clock_i), .rst_i(rst_i), .cfg_done_i(cfg_done_i),
  .reboot_after_save_i(reboot_after_save_i), .reboot_req_o(reboot_req_o),
  .adc_valid_i(adc_valid_i), .adc_valid_o(adc_valid_o),
  .output_set_command_i(output_set_command_i), .output_set_ch_i(output_set_ch_i),
  .dac_we_o(dac_we_o), .dac_ch_o(dac_ch_o), .dac_data_o(dac_data_o));

// ===== verif/acd_conv_model.sv
`timescale 1ns/100ps
module acd_conv_model
(
  input wire clock_i, // clock
  input wire dac_we_i, // converter strobe
  input wire dac_ch_i, // converter channel
  input wire [11:0] dac_data_i, // converter code
  output reg smp_valid_o, // sample strobe
  output reg [2:0] smp_ch_o, // sample channel
  output reg [11:0] smp_data_o // sample code
);
  reg [11:0] dac_word_q [0:1];
  initial
  begin
    smp_valid_o = 1'b0;
    smp_ch_o = 3'h0;
    smp_data_o = 12'h000;
  end
  always @(posedge clock_i)
    if (dac_we_i)
      dac_word_q[dac_ch_i] <= dac_data_i;
  task convert(input [2:0] c, input [11:0] code);
  begin
    @(negedge clock_i);
    smp_valid_o = 1'b1;
    smp_ch_o = c;
    smp_data_o = code;
    @(negedge clock_i);
    smp_valid_o = 1'b0;
    // Outside the strobe the lines carry junk, so a stale code cannot pass.
    smp_data_o = ~code;
  end
  endtask
endmodule // acd_conv_model

// ===== verif/acd_calib_datapath_tb.sv
`timescale 1ns/100ps
module acd_calib_datapath_tb;
  reg clock_i, rst_i, cold_boot_i, cfg_we_i, cfg_done_i, reboot_after_save_i;
  reg output_set_command_i, output_set_ch_i;
  reg [1:0] cfg_sel_i;
  reg [2:0] cfg_ch_i;
  reg [15:0] cfg_data_i;
  reg [4:0] cfg_avg_i;
  reg [11:0] output_set_value_i;
  wire reboot_req_o, adc_valid_i, adc_valid_o, dac_we_o, dac_ch_o;
  wire [2:0] adc_ch_i, adc_ch_o;
  wire [11:0] adc_data_i, adc_data_o, dac_data_o;
  integer n_mismatch, num_checks, k;
  acd_calib_datapath acd_calib_datapath_i (.clock_i(clock_i), .rst_i(rst_i),
    .cold_boot_i(cold_boot_i), .cfg_we_i(cfg_we_i), .cfg_sel_i(cfg_sel_i),
    .cfg_ch_i(cfg_ch_i), .cfg_data_i(cfg_data_i), .cfg_avg_i(cfg_avg_i),
    .cfg_done_i(cfg_done_i), .reboot_after_save_i(reboot_after_save_i),
    .reboot_req_o(reboot_req_o), .adc_valid_i(adc_valid_i), .adc_ch_i(adc_ch_i),
    .adc_data_i(adc_data_i), .adc_valid_o(adc_valid_o), .adc_ch_o(adc_ch_o),
    .adc_data_o(adc_data_o), .output_set_command_i(output_set_command_i),
    .output_set_ch_i(output_set_ch_i), .output_set_value_i(output_set_value_i),
    .dac_we_o(dac_we_o), .dac_ch_o(dac_ch_o), .dac_data_o(dac_data_o));
  acd_conv_model acd_conv_model_i (.clock_i(clock_i), .dac_we_i(dac_we_o),
    .dac_ch_i(dac_ch_o), .dac_data_i(dac_data_o), .smp_valid_o(adc_valid_i),
    .smp_ch_o(adc_ch_i), .smp_data_o(adc_data_i));
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task check(input [15:0] seen, input [15:0] exp, input [79:0] what);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0s expected %0d seen %0d", what, exp, seen);
    end
  end
  endtask
  function [11:0] corr(input integer v, input integer g, input integer o);
    integer p, r;
  begin
    p = v * g;
    r = p >= 0 ? (p + 5000) / 10000 : -((5000 - p) / 10000);
    r = v + r + (o > 100 ? 100 : o < -100 ? -100 : o);
    corr = r < 0 ? 12'h000 : r > 4095 ? 12'hFFF : r[11:0];
  end
  endfunction
  task cfg(input [1:0] s, input [2:0] c, input [15:0] d);
  begin
    @(negedge clock_i);
    cfg_we_i = 1'b1;
    cfg_sel_i = s;
    cfg_ch_i = c;
    cfg_data_i = d;
    @(negedge clock_i);
    cfg_we_i = 1'b0;
  end
  endtask
  task boot;
  begin
    @(negedge clock_i);
    cold_boot_i = 1'b1;
    @(negedge clock_i);
    cold_boot_i = 1'b0;
  end
  endtask
  task done(input rq);
  begin
    @(negedge clock_i);
    cfg_done_i = 1'b1;
    @(negedge clock_i);
    cfg_done_i = 1'b0;
    check(reboot_req_o, rq, "reboot");
    repeat (2) @(negedge clock_i);
  end
  endtask
  task dac(input c, input [11:0] v, input [11:0] exp);
  begin
    @(negedge clock_i);
    output_set_command_i = 1'b1;
    output_set_ch_i = c;
    output_set_value_i = v;
    @(negedge clock_i);
    output_set_command_i = 1'b0;
    check(dac_we_o, 1, "dac_we");
    check(dac_ch_o, c, "dac_ch");
    check(dac_data_o, exp, "dac_data");
    @(negedge clock_i);
    check(acd_conv_model_i.dac_word_q[c], exp, "dac_word");
  end
  endtask
  task adc(input [2:0] c, input [11:0] code, input [11:0] exp, input chk);
  begin
    acd_conv_model_i.convert(c, code);
    k = 0;
    while (adc_valid_o !== 1'b1 && k < 40)
    begin
      @(negedge clock_i);
      k = k + 1;
    end
    check(adc_valid_o, 1, "adc_valid");
    check(adc_ch_o, c, "adc_ch");
    if (chk)
      check(adc_data_o, exp, "adc_data");
  end
  endtask
  task complete_run;
  begin
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial
  begin
    {cold_boot_i, cfg_we_i, cfg_done_i, reboot_after_save_i} = 4'h0;
    {output_set_command_i, output_set_ch_i, cfg_sel_i, cfg_ch_i} = 7'h00;
    cfg_data_i = 16'h0000;
    output_set_value_i = 12'h000;
    cfg_avg_i = 5'h01;
    n_mismatch = 0;
    num_checks = 0;
    rst_i = 1'b1;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    dac(0, 12'h800, 12'h800);
    adc(3, 12'h800, 12'h800, 1);
    cfg(2, 0, -16'sd1000);
    cfg(3, 0, 16'sd300);
    dac(0, 12'h800, 12'h800);
    boot;
    dac(0, 12'h800, corr(2048, -1000, 300));
    dac(0, 12'hFFF, corr(4095, -1000, 300));
    cfg(2, 1, 16'sd146);
    cfg(3, 1, 16'sd0);
    done(0);
    dac(1, 12'hFFF, 12'hFFF);
    reboot_after_save_i = 1'b1;
    done(1);
    reboot_after_save_i = 1'b0;
    dac(1, 12'hFFF, corr(4095, 146, 0));
    dac(1, 12'h800, corr(2048, 146, 0));
    cfg(0, 3, -16'sd58);
    cfg(1, 3, -16'sd100);
    boot;
    adc(3, 12'h80C, corr(2060, -58, -100), 1);
    adc(3, 12'h032, corr(50, -58, -100), 1);
    adc(3, 12'h3E8, corr(1000, -58, -100), 1);
    cfg_avg_i = 5'h04;
    cfg(0, 5, 16'sd0);
    boot;
    adc(5, 12'h064, 12'h064, 1);
    adc(5, 12'h0C8, 12'h096, 1);
    adc(5, 12'h12C, 12'h0C8, 1);
    adc(5, 12'h190, 12'h0FA, 1);
    adc(5, 12'h1F4, 12'h15E, 1);
    adc(5, 12'h1F7, 12'h1A9, 1);
    cfg_avg_i = 5'h00;
    cfg(1, 5, 16'sd0);
    boot;
    adc(5, 12'h123, 12'h123, 1);
    complete_run;
  end
endmodule // acd_calib_datapath_tb
